/* design/ifci_pkg.sv */
/*
 * Constants, register map and carrier types for the integrity field
 * check / insert engine.
 * Assumes one 100 MHz clock and an APB master with 32-bit data.
 */
package ifci_pkg;
    // Operation codes
    localparam logic [7:0] OP_VERIFY = 8'h12;
    localparam logic [7:0] OP_INSERT = 8'h13;

    // Source block sizes in bytes, chosen by the two low option bits
    localparam logic [12:0] BLK_512 = 13'h0200;
    localparam logic [12:0] BLK_520 = 13'h0208;
    localparam logic [12:0] BLK_4096 = 13'h1000;
    localparam logic [12:0] BLK_4104 = 13'h1008;
    localparam logic [12:0] FIELD_BYTES = 13'h0008;
    localparam logic [2:0] FIELD_LAST = 3'h7;
    localparam logic [1:0] REC_LAST = 2'h3;
    localparam logic [1:0] REC_TAGS = 2'h2;
    localparam int GROW_SHIFT_SMALL = 6;
    localparam int GROW_SHIFT_LARGE = 9;

    // Completion status codes
    localparam logic [7:0] ST_NONE = 8'h00;
    localparam logic [7:0] ST_SUCCESS = 8'h01;
    localparam logic [7:0] ST_FAULT = 8'h03;
    localparam logic [7:0] ST_INTEGRITY = 8'h06;
    localparam logic [7:0] ST_OVERLAP = 8'h10;
    localparam logic [7:0] ST_BADOP = 8'h11;

    // Integrity error kinds
    localparam logic [7:0] KIND_NONE = 8'h00;
    localparam logic [7:0] KIND_GUARD = 8'h01;
    localparam logic [7:0] KIND_APP = 8'h02;
    localparam logic [7:0] KIND_REF = 8'h04;

    // Register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_OPCODE = 12'h004;
    localparam logic [11:0] REG_SRC = 12'h008;
    localparam logic [11:0] REG_DST = 12'h00C;
    localparam logic [11:0] REG_CMP = 12'h010;
    localparam logic [11:0] REG_XFER = 12'h014;
    localparam logic [11:0] REG_OPTS = 12'h018;
    localparam logic [11:0] REG_REFSEED = 12'h01C;
    localparam logic [11:0] REG_APPSEED = 12'h020;
    localparam logic [11:0] REG_STATUS = 12'h024;
    localparam logic [11:0] REG_BYTES = 12'h028;
    localparam logic [11:0] REG_REFTAG = 12'h02C;
    localparam logic [11:0] REG_IRQSTAT = 12'h030;
    localparam logic [11:0] REG_IRQMASK = 12'h034;

    // Field positions
    localparam int CTRL_START = 0;
    localparam int OPT_REC_VALID = 8;
    localparam int OPT_REC_REQ = 9;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_GUARD = 16'h0000;

    typedef struct packed {
        logic [31:0] addr;
        logic [63:0] data;
        logic wide;
    } ifci_wr_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CHECK = 3'b001,
        S_RD = 3'b010,
        S_WR = 3'b011,
        S_INS = 3'b100,
        S_REC = 3'b101,
        S_DONE = 3'b110
    } ifci_state_t;
endpackage : ifci_pkg

/* design/ifci_engine.sv */
/*
 * Descriptor-driven integrity field engine: verify (source blocks carry
 * their field) and insert (copy, appending a generated field per block).
 * Assumes APB registers, a byte read port and a write port that take a
 * request held until its one-cycle ack, and a completion record in memory.
 */
// The APB register port and the address map were decided locally.
// How it works
// - Opcode 0x12 verifies the field embedded after each source block.
// - Opcode 0x13 copies source to destination and inserts a field per block.
// - Field computed per block of 512, 520, 4096 or 4104 bytes.
// - Verify reads exactly the transfer size in source bytes.
// - Insert copies exactly the transfer size in source bytes.
// - Insert writes transfer size plus eight bytes per whole block; a short tail block gets no field.
// - Any byte alignment of addresses is accepted without fault.
// - Insert with overlapping source and destination regions reports an error.
// - Success writes final reference and application tags with success status.
// - A page fault reports the updated tags with the fault address.
// - Verify mismatch stops with integrity status and the error kind.
// - Bytes completed excludes the whole block holding the error.
// - Verify compares each computed field against the embedded one.
module ifci_engine import ifci_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic rdReq,
    output logic [31:0] rdAddr,
    input wire logic rdAck,
    input wire logic [7:0] rdData,
    input wire logic rdFault,
    output logic wrReq,
    output ifci_wr_t wrCmd,
    input wire logic wrAck,
    output logic irq
);
    logic [7:0] opcode_q;
    logic [31:0] srcBase_q, dstBase_q, cmpAddr_q, xfer_q, opts_q, refSeed_q, appSeed_q;
    logic [1:0] irqMask_q, irqStat_q, irqStat_d;
    logic [31:0] prdata_q, rdMux;
    logic pready_q, pslverr_q, irq_q;
    ifci_state_t state_q, state_d;
    logic [31:0] srcAddr_q, srcAddr_d, dstAddr_q, dstAddr_d, remain_q, remain_d;
    logic [31:0] refTag_q, refTag_d, bytesDone_q, bytesDone_d, faultAddr_q, faultAddr_d;
    logic [12:0] blkCnt_q, blkCnt_d, blkSize_q, blkSize_d;
    logic [15:0] guard_q, guard_d;
    logic [63:0] fieldSh_q, fieldSh_d;
    logic [2:0] fIdx_q, fIdx_d;
    logic [7:0] status_q, status_d, kind_q, kind_d;
    logic [1:0] recIdx_q, recIdx_d;
    logic inField_q, inField_d, rdReq_q, wrReq_q;
    logic [31:0] rdAddr_q;
    ifci_wr_t wrCmd_q, wrCmd_d;

    // Bus decode
    wire access = psel & penable;
    wire wrEn = access & pwrite & pready_q;
    wire rdDone = access & ~pwrite & pready_q;
    wire idle = (state_q == S_IDLE);
    wire descWr = wrEn & idle;
    wire startPulse = descWr & (paddr == REG_CTRL) & pwdata[CTRL_START];
    wire hit = (paddr <= REG_IRQMASK) & (paddr[1:0] == 2'b00);
    wire [15:0] appTag = appSeed_q[15:0];
    wire [15:0] appMask = appSeed_q[31:16];
    wire isInsert = (opcode_q == OP_INSERT);
    wire validOp = (opcode_q == OP_VERIFY) | isInsert;
    wire recOn = opts_q[OPT_REC_VALID] & opts_q[OPT_REC_REQ];
    wire [1:0] blkSel = opts_q[1:0];
    wire [12:0] blkSizeSel = (blkSel == 2'd0) ? BLK_512 : (blkSel == 2'd1) ? BLK_520 :
        (blkSel == 2'd2) ? BLK_4096 : BLK_4104;

    // Overlap bound; a whole extra field covers a short tail block
    wire [32:0] growth = ((blkSel[1] ? {1'b0, xfer_q >> GROW_SHIFT_LARGE} :
        {1'b0, xfer_q >> GROW_SHIFT_SMALL}) + {20'h0_0000, FIELD_BYTES});
    wire [32:0] srcEnd = {1'b0, srcBase_q} + {1'b0, xfer_q};
    wire [32:0] dstEnd = {1'b0, dstBase_q} + {1'b0, xfer_q} + growth;
    wire overlap = ({1'b0, srcBase_q} < dstEnd) & ({1'b0, dstBase_q} < srcEnd) & (xfer_q != RST_WORD);

    wire [63:0] fieldIn = {fieldSh_q[55:0], rdData};
    wire guardBad = (fieldIn[63:48] != guard_q);
    wire appBad = ((fieldIn[47:32] & ~appMask) != (appTag & ~appMask));
    wire refBad = (fieldIn[31:0] != refTag_q);
    wire mismatch = guardBad | appBad | refBad;
    wire [15:0] guardNext = {guard_q[14:0], guard_q[15]} ^ {8'h00, rdData};
    wire blkLast = (blkCnt_q == blkSize_q - 13'h0001);
    wire [31:0] blkPlusField = {19'h0_0000, blkSize_q + FIELD_BYTES};
    wire [31:0] blkOnly = {19'h0_0000, blkSize_q};

    assign rdMux = (paddr == REG_OPCODE) ? {24'h00_0000, opcode_q} :
        (paddr == REG_SRC) ? srcBase_q : (paddr == REG_DST) ? dstBase_q :
        (paddr == REG_CMP) ? cmpAddr_q : (paddr == REG_XFER) ? xfer_q :
        (paddr == REG_OPTS) ? opts_q : (paddr == REG_REFSEED) ? refSeed_q :
        (paddr == REG_APPSEED) ? appSeed_q :
        (paddr == REG_STATUS) ? {15'h0000, ~idle, kind_q, status_q} :
        (paddr == REG_BYTES) ? bytesDone_q : (paddr == REG_REFTAG) ? refTag_q :
        (paddr == REG_IRQSTAT) ? {30'h0000_0000, irqStat_q} :
        (paddr == REG_IRQMASK) ? {30'h0000_0000, irqMask_q} : RST_WORD;

    // Events win over the clearing read in the same cycle
    wire doneEv = (state_q == S_DONE);
    wire [1:0] irqSet = {doneEv & (status_q != ST_SUCCESS), doneEv};
    assign irqStat_d = (irqStat_q & ~{2{rdDone & (paddr == REG_IRQSTAT)}}) | irqSet;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= RST_WORD;
            irqStat_q <= 2'b00;
            irq_q <= 1'b0;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~hit;
            prdata_q <= (access & ~pready_q) ? rdMux : prdata_q;
            irqStat_q <= irqStat_d;
            irq_q <= |(irqStat_d & irqMask_q);
        end
    end

    // Descriptor registers are frozen while an operation runs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            opcode_q <= 8'h00;
            {srcBase_q, dstBase_q, cmpAddr_q, xfer_q} <= {4{RST_WORD}};
            {opts_q, refSeed_q, appSeed_q} <= {3{RST_WORD}};
            irqMask_q <= 2'b00;
        end else begin
            if (descWr & (paddr == REG_OPCODE)) opcode_q <= pwdata[7:0];
            if (descWr & (paddr == REG_SRC)) srcBase_q <= pwdata;
            if (descWr & (paddr == REG_DST)) dstBase_q <= pwdata;
            if (descWr & (paddr == REG_CMP)) cmpAddr_q <= pwdata;
            if (descWr & (paddr == REG_XFER)) xfer_q <= pwdata;
            if (descWr & (paddr == REG_OPTS)) opts_q <= pwdata;
            if (descWr & (paddr == REG_REFSEED)) refSeed_q <= pwdata;
            if (descWr & (paddr == REG_APPSEED)) appSeed_q <= pwdata;
            if (wrEn & (paddr == REG_IRQMASK)) irqMask_q <= pwdata[1:0];
        end
    end

    always_comb begin
        state_d = state_q;
        srcAddr_d = srcAddr_q;
        dstAddr_d = dstAddr_q;
        remain_d = remain_q;
        refTag_d = refTag_q;
        bytesDone_d = bytesDone_q;
        faultAddr_d = faultAddr_q;
        blkCnt_d = blkCnt_q;
        blkSize_d = blkSize_q;
        guard_d = guard_q;
        fieldSh_d = fieldSh_q;
        fIdx_d = fIdx_q;
        status_d = status_q;
        kind_d = kind_q;
        recIdx_d = recIdx_q;
        inField_d = inField_q;
        wrCmd_d = wrCmd_q;
        unique case (state_q)
            S_IDLE: begin
                if (startPulse) begin
                    {srcAddr_d, dstAddr_d, remain_d} = {srcBase_q, dstBase_q, xfer_q};
                    {refTag_d, bytesDone_d, faultAddr_d} = {refSeed_q, RST_WORD, RST_WORD};
                    {blkCnt_d, blkSize_d, guard_d} = {13'h0000, blkSizeSel, RST_GUARD};
                    {status_d, kind_d, fIdx_d, inField_d} = {ST_NONE, KIND_NONE, 3'h0, 1'b0};
                    state_d = S_CHECK;
                end
            end
            S_CHECK: begin
                // No alignment test on any address
                state_d = recOn ? S_REC : S_DONE;
                recIdx_d = 2'h0;
                if (!validOp) begin
                    status_d = ST_BADOP;
                end else if (isInsert & overlap) begin
                    status_d = ST_OVERLAP;
                end else if (remain_q == RST_WORD) begin
                    status_d = ST_SUCCESS;
                end else begin
                    state_d = S_RD;
                end
            end
            S_RD: begin
                if (rdAck) begin
                    srcAddr_d = srcAddr_q + 32'h0000_0001;
                    // Every source byte counts against the size
                    remain_d = remain_q - 32'h0000_0001;
                    if (rdFault) begin
                        // Tags stay as of the last whole block
                        {srcAddr_d, remain_d} = {srcAddr_q, remain_q};
                        {status_d, faultAddr_d, recIdx_d} = {ST_FAULT, srcAddr_q, 2'h0};
                        state_d = recOn ? S_REC : S_DONE;
                    end else if (inField_q) begin
                        fieldSh_d = fieldIn;
                        fIdx_d = fIdx_q + 3'h1;
                        if (fIdx_q == FIELD_LAST) begin
                            inField_d = 1'b0;
                            recIdx_d = 2'h0;
                            if (mismatch) begin
                                status_d = ST_INTEGRITY;
                                kind_d = guardBad ? KIND_GUARD : appBad ? KIND_APP : KIND_REF;
                                state_d = recOn ? S_REC : S_DONE;
                            end else begin
                                bytesDone_d = bytesDone_q + blkPlusField;
                                refTag_d = refTag_q + 32'h0000_0001;
                                {guard_d, blkCnt_d} = {RST_GUARD, 13'h0000};
                                if (remain_d == RST_WORD) begin
                                    status_d = ST_SUCCESS;
                                    state_d = recOn ? S_REC : S_DONE;
                                end
                            end
                        end else if (remain_d == RST_WORD) begin
                            // A cut field ends the run instead of reading past the size
                            {status_d, recIdx_d} = {ST_SUCCESS, 2'h0};
                            state_d = recOn ? S_REC : S_DONE;
                        end
                    end else begin
                        // Guard runs over the block data
                        guard_d = guardNext;
                        blkCnt_d = blkCnt_q + 13'h0001;
                        if (isInsert) begin
                            // Each source byte goes out unchanged
                            wrCmd_d = '{addr: dstAddr_q, data: {56'h0, rdData}, wide: 1'b0};
                            state_d = S_WR;
                        end else if (blkLast) begin
                            {inField_d, fIdx_d} = {1'b1, 3'h0};
                        end
                        if (!isInsert & (remain_d == RST_WORD)) begin
                            {status_d, recIdx_d} = {ST_SUCCESS, 2'h0};
                            state_d = recOn ? S_REC : S_DONE;
                        end
                    end
                end
            end
            S_WR: begin
                if (wrAck) begin
                    dstAddr_d = dstAddr_q + 32'h0000_0001;
                    recIdx_d = 2'h0;
                    if (blkCnt_q == blkSize_q) begin
                        fieldSh_d = {guard_q, appTag, refTag_q};
                        {fIdx_d, state_d} = {3'h0, S_INS};
                    end else if (remain_q == RST_WORD) begin
                        status_d = ST_SUCCESS;
                        state_d = recOn ? S_REC : S_DONE;
                    end else begin
                        state_d = S_RD;
                    end
                end
            end
            S_INS: begin
                if (wrAck) begin
                    // Eight field bytes follow each whole block
                    dstAddr_d = dstAddr_q + 32'h0000_0001;
                    fieldSh_d = {fieldSh_q[55:0], 8'h00};
                    fIdx_d = fIdx_q + 3'h1;
                    if (fIdx_q == FIELD_LAST) begin
                        bytesDone_d = bytesDone_q + blkOnly;
                        refTag_d = refTag_q + 32'h0000_0001;
                        {guard_d, blkCnt_d, recIdx_d} = {RST_GUARD, 13'h0000, 2'h0};
                        state_d = S_RD;
                        if (remain_q == RST_WORD) begin
                            status_d = ST_SUCCESS;
                            state_d = recOn ? S_REC : S_DONE;
                        end
                    end
                end
            end
            S_REC: begin
                if (wrAck) begin
                    recIdx_d = recIdx_q + 2'h1;
                    if (recIdx_q == REC_LAST) state_d = S_DONE;
                end
            end
            S_DONE: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
        if (state_d == S_INS) begin
            wrCmd_d = '{addr: dstAddr_d, data: {56'h0, fieldSh_d[63:56]}, wide: 1'b0};
        end
        // Record words carry status, count, fault and final tags
        if (state_d == S_REC) begin
            wrCmd_d.addr = cmpAddr_q + {27'h000_0000, recIdx_d, 3'b000};
            wrCmd_d.wide = 1'b1;
            unique case (recIdx_d)
                2'h0: wrCmd_d.data = {bytesDone_d, 16'h0000, kind_d, status_d};
                2'h1: wrCmd_d.data = {32'h0000_0000, faultAddr_d};
                2'h2: wrCmd_d.data = {appTag, appMask, refTag_d};
                2'h3: wrCmd_d.data = 64'h0000_0000_0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            {srcAddr_q, dstAddr_q, remain_q, refTag_q} <= {4{RST_WORD}};
            {bytesDone_q, faultAddr_q, rdAddr_q} <= {3{RST_WORD}};
            {blkCnt_q, blkSize_q, guard_q, fieldSh_q} <= '0;
            {fIdx_q, status_q, kind_q, recIdx_q, inField_q} <= '0;
            {rdReq_q, wrReq_q, wrCmd_q} <= '0;
        end else begin
            state_q <= state_d;
            {srcAddr_q, dstAddr_q, remain_q, refTag_q} <= {srcAddr_d, dstAddr_d, remain_d, refTag_d};
            {bytesDone_q, faultAddr_q} <= {bytesDone_d, faultAddr_d};
            {blkCnt_q, blkSize_q, guard_q, fieldSh_q} <= {blkCnt_d, blkSize_d, guard_d, fieldSh_d};
            {fIdx_q, status_q, kind_q, recIdx_q, inField_q} <= {fIdx_d, status_d, kind_d, recIdx_d, inField_d};
            rdReq_q <= (state_d == S_RD);
            rdAddr_q <= srcAddr_d;
            // One write port, so the record queues behind the data
            wrReq_q <= (state_d == S_WR) | (state_d == S_INS) | (state_d == S_REC);
            wrCmd_q <= wrCmd_d;
        end
    end

    assign {prdata, pready, pslverr, irq} = {prdata_q, pready_q, pslverr_q, irq_q};
    assign {rdReq, rdAddr, wrReq, wrCmd} = {rdReq_q, rdAddr_q, wrReq_q, wrCmd_q};

    sequence s_insRead;
        (state_q == S_RD) && rdAck && !rdFault && isInsert && !inField_q;
    endsequence
    sequence s_fieldEnd;
        (state_q == S_INS) && wrAck && (fIdx_q == FIELD_LAST);
    endsequence

    property p_badop;
        @(posedge core_clk) disable iff (sys_rst)
        (state_q == S_CHECK) && !validOp |=> (status_q == ST_BADOP) && !rdReq_q;
    endproperty
    a_badop: assert property (p_badop) else $error("bad opcode not rejected");
    property p_insCopy;
        @(posedge core_clk) disable iff (sys_rst)
        s_insRead |=> wrReq_q && (wrCmd_q.data[7:0] == $past(rdData)) && (wrCmd_q.addr == dstAddr_q);
    endproperty
    a_insCopy: assert property (p_insCopy) else $error("copied byte not written");
    property p_blockField;
        @(posedge core_clk) disable iff (sys_rst)
        s_fieldEnd |=> (blkCnt_q == 13'h0000) && (bytesDone_q == $past(bytesDone_q) + $past(blkOnly));
    endproperty
    a_blockField: assert property (p_blockField) else $error("block count wrong after field");
    property p_remain;
        @(posedge core_clk) disable iff (sys_rst)
        (state_q == S_RD) && rdAck && !rdFault |=> remain_q == $past(remain_q) - 32'h0000_0001;
    endproperty
    a_remain: assert property (p_remain) else $error("remaining count not decremented");
    property p_overlap;
        @(posedge core_clk) disable iff (sys_rst)
        (state_q == S_CHECK) && isInsert && overlap |=> (status_q == ST_OVERLAP) && !wrReq_q | recOn;
    endproperty
    a_overlap: assert property (p_overlap) else $error("overlap not reported");
    property p_fault;
        @(posedge core_clk) disable iff (sys_rst)
        (state_q == S_RD) && rdAck && rdFault |=>
            (status_q == ST_FAULT) && $stable(refTag_q) && (faultAddr_q == $past(srcAddr_q));
    endproperty
    a_fault: assert property (p_fault) else $error("fault record wrong");
    property p_integ;
        @(posedge core_clk) disable iff (sys_rst)
        (state_q == S_RD) && rdAck && !rdFault && inField_q && (fIdx_q == FIELD_LAST) && mismatch |=>
            (status_q == ST_INTEGRITY) && $stable(bytesDone_q) && (kind_q != KIND_NONE);
    endproperty
    a_integ: assert property (p_integ) else $error("integrity error not reported");
    property p_recTags;
        @(posedge core_clk) disable iff (sys_rst)
        (state_q == S_REC) && (recIdx_q == REC_TAGS) |-> wrCmd_q.wide && (wrCmd_q.data[31:0] == refTag_q);
    endproperty
    a_recTags: assert property (p_recTags) else $error("record tags wrong");
endmodule : ifci_engine

/* tb/ifci_mem_model.sv */
/* Memory partner: byte array that answers reads and writes.
   Assumes the engine holds each request until its ack. */
module ifci_mem_model import ifci_pkg::*; (
    input wire logic core_clk,
    input wire logic rdReq,
    input wire logic [31:0] rdAddr,
    output logic rdAck,
    output logic [7:0] rdData,
    output logic rdFault,
    input wire logic wrReq,
    input wire ifci_wr_t wrCmd,
    output logic wrAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:4095];
    logic [31:0] faultAt = '1;
    logic [63:0] rec [0:3];
    logic [31:0] dstLo, dstHi;
    int nByte, nWide, late, tick;
    initial begin
        rdAck = 0;
        wrAck = 0;
        rdData = 0;
        rdFault = 0;
        foreach (mem[i]) mem[i] = 0;
    end
    // Stalls one cycle in four; idle data toggles so it is never stale
    always @(posedge core_clk) begin
        tick <= tick + 1;
        rdAck <= rdReq && !rdAck && tick[1:0] != 0;
        rdData <= rdReq ? mem[rdAddr[11:0]] : ~rdData;
        rdFault <= rdReq && rdAddr == faultAt;
        wrAck <= wrReq && !wrAck;
        if (wrReq && !wrAck && wrCmd.wide) begin
            if (nWide < 4) rec[nWide] <= wrCmd.data;
            nWide <= nWide + 1;
        end else if (wrReq && !wrAck) begin
            if (nByte == 0) dstLo <= wrCmd.addr;
            dstHi <= wrCmd.addr;
            nByte <= nByte + 1;
            if (nWide != 0) late <= late + 1;
        end
    end
endmodule : ifci_mem_model

/* tb/integrity_field_check_insert_test.sv */
/* Self-checking bench: APB calls run operations against the memory model.
   Assumes ifci_pkg and the engine's hand-over timing. */
module integrity_field_check_insert_test import ifci_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, irq, rdReq, rdAck, rdFault, wrReq, wrAck, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdAddr, rd;
    logic [7:0] rdData;
    ifci_wr_t wrCmd;
    int failures, n_compared;
    initial forever #5 core_clk = ~core_clk;
    ifci_engine u_dut (.core_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .rdReq, .rdAddr, .rdAck, .rdData, .rdFault, .wrReq, .wrCmd, .wrAck, .irq);
    ifci_mem_model u_mem (.core_clk, .rdReq, .rdAddr, .rdAck, .rdData, .rdFault, .wrReq, .wrCmd, .wrAck);
    task automatic check(string name, logic [63:0] exp, logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h got %h", name, exp, got);
        end
    endtask : check
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic runOp(logic [7:0] op, logic [31:0] src, logic [31:0] dst, logic [31:0] xfer,
        logic [1:0] bs = 2'h0);
        u_mem.nByte = 0;
        u_mem.nWide = 0;
        u_mem.late = 0;
        apb(1, REG_SRC, src);
        apb(1, REG_DST, dst);
        apb(1, REG_CMP, 32'h0000_0F00);
        apb(1, REG_XFER, xfer);
        // Block size code bs with the completion record requested
        apb(1, REG_OPTS, {22'h00_0000, 2'h3, 6'h00, bs}); // record enable
        apb(1, REG_OPCODE, {24'h00_0000, op});
        apb(1, REG_CTRL, 32'h0000_0001);
        do apb(0, REG_STATUS, 0); while (rd[16] !== 0);
    endtask : runOp
    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 0;
        apb(1, REG_IRQMASK, 32'h0000_0003);
        runOp(OP_INSERT, 32'h0000_0101, 32'h0000_0803, 32'h0000_0200); // odd addresses
        check("status", ST_SUCCESS, rd[7:0]); // success code
        check("dst bytes", 520, u_mem.nByte); // output size
        check("dst first", 32'h0000_0803, u_mem.dstLo); // unaligned destination
        check("dst last", 32'h0000_0A0A, u_mem.dstHi); // field after block
        check("late writes", 0, u_mem.late); // record last
        check("rec bytes", 512, u_mem.rec[0][63:32]); // source count
        check("rec ref tag", 1, u_mem.rec[2][31:0]); // final tag
        repeat (2) @(posedge core_clk);
        check("irq", 1, irq);
        apb(0, REG_IRQSTAT, 0);
        check("irq stat", 1, rd[1:0]);
        apb(0, REG_IRQSTAT, 0);
        check("irq clear", 0, rd[1:0]);
        runOp(OP_VERIFY, 0, 0, 520); // one block plus its field
        check("status", ST_SUCCESS, rd[7:0]); // field matches
        check("rec bytes", 520, u_mem.rec[0][63:32]); // bytes read
        check("dst bytes", 0, u_mem.nByte); // no data written
        runOp(OP_VERIFY, 0, 0, 528, 2'h1); // block size 520
        check("status", ST_SUCCESS, rd[7:0]); // field matches
        check("rec bytes", 528, u_mem.rec[0][63:32]); // whole block counted
        u_mem.mem[12'h20A] = 8'h01;
        runOp(OP_VERIFY, 0, 0, 1040); // bad second block
        check("status", ST_INTEGRITY, rd[7:0]); // error code
        check("kind", KIND_GUARD, u_mem.rec[0][15:8]); // error kind
        check("rec bytes", 520, u_mem.rec[0][63:32]); // block excluded
        runOp(OP_INSERT, 32'h0000_0100, 32'h0000_0100, 32'h0000_0200); // same region
        check("status", ST_OVERLAP, rd[7:0]); // overlap code
        runOp(8'h55, 0, 0, 0); // undecoded opcode
        check("status", ST_BADOP, rd[7:0]); // opcode rejected
        apb(1, REG_IRQMASK, 0);
        apb(0, REG_IRQSTAT, 0);
        u_mem.faultAt = 32'h0000_0303;
        runOp(OP_INSERT, 32'h0000_0100, 32'h0000_0800, 32'h0000_0400); // fault in second block
        check("status", ST_FAULT, rd[7:0]); // fault code
        check("fault addr", 32'h0000_0303, u_mem.rec[1][31:0]); // fault address
        check("fault ref tag", 1, u_mem.rec[2][31:0]); // tag after whole block
        check("masked irq", 0, irq);
        apb(0, REG_IRQSTAT, 0);
        check("irq stat err", 3, rd[1:0]);
        u_mem.faultAt = '1;
        apb(1, REG_REFSEED, u_mem.rec[2][31:0]); // reported tag as seed
        runOp(OP_INSERT, 32'h0000_0300, 32'h0000_0A08, 32'h0000_0200); // whole block resume
        check("status", ST_SUCCESS, rd[7:0]); // resumed run
        check("rec ref tag", 2, u_mem.rec[2][31:0]); // tag continues
        apb(0, 12'h0FC, 0);
        check("unmapped", 1, err);
        stop_test();
    end
endmodule : integrity_field_check_insert_test
